// ### lfa_top.sv
`timescale 1ns/100ps
`include "lfa_defines.svh"
module lfa_top import lfa_pkg::*; #(
	parameter int SENSOR_PIX = `LFA_SENSOR_PIX,
	parameter int DEPTH = `LFA_BUF_DEPTH,
	parameter int NBUF = `LFA_NBUF
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Sensor line source
	input wire logic sns_valid_i,
	input wire logic [`LFA_DATA_W-1:0] sns_data_i,
	input wire logic sns_last_i,
	// Acquisition control
	input wire logic acq_begin_command_i,
	input wire logic acq_halt_command_i,
	input wire logic single_frame_i,
	input wire logic geom_wr_i,
	input wire lfa_geom_t geom_i,
	input wire logic overrun_clr_i,
	// Status and limits
	output lfa_geom_t geom_o,
	output logic geom_pend_o,
	output lfa_geom_t geom_max_o,
	output lfa_geom_t geom_inc_o,
	output logic acquiring_o,
	output logic overrun_o,
	// Network transmit path
	output lfa_tx_t tx_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i
);
	localparam int BW = (NBUF > 1) ? $clog2(NBUF) : 1;
	localparam int PW = `LFA_PIX_W;
	localparam int LW = `LFA_LINE_W;
	localparam int CW = `LFA_CNT_W;
	localparam logic [CW:0] DEPTH_C = (CW+1)'(DEPTH);

	logic acq_q, halt_pend_q, take_q, overrun_q, pend_q;
	logic [PW-1:0] pix_idx_q, cur_first_q, cur_count_q;
	lfa_geom_t app_q, pend_geom_q;
	logic [LW-1:0] lines_eff_q, line_cnt_q;
	logic [BW-1:0] wr_buf_q, rd_buf_q;
	logic [CW-1:0] wr_ptr_q, rd_cnt_q;
	logic [PW-1:0] col_q;
	logic [NBUF-1:0] full_q;
	logic [CW-1:0] words_q [NBUF];
	logic [PW-1:0] width_q [NBUF];
	lfa_tx_t tx_q;
	logic tx_valid_q;
	lfa_geom_t max_q;

	// Line framing and crop window
	logic line_first, mid_line, line_end, halting, start_take, start_drop, taking;
	logic [PW-1:0] first_now, count_now;
	logic [PW:0] win_end;
	logic in_win, line_done, lines_reached, no_room;
	logic [CW-1:0] ptr_next;
	logic frame_close, stop_now, apply;
	assign line_first = sns_valid_i && (pix_idx_q == '0);
	assign mid_line = (pix_idx_q != '0);
	assign line_end = sns_valid_i && sns_last_i;
	assign halting = acq_q && (halt_pend_q || acq_halt_command_i);
	assign start_take = line_first && acq_q && !halting && !full_q[wr_buf_q];
	assign start_drop = line_first && acq_q && !halting && full_q[wr_buf_q];
	assign taking = line_first ? start_take : take_q;
	// Window is caught at line start so a mid-line write cannot tear a line
	assign first_now = line_first ? app_q.aoi_first_pixel : cur_first_q;
	assign count_now = line_first ? app_q.pixel_count : cur_count_q;
	assign win_end = {1'b0, first_now} + {1'b0, count_now};
	assign in_win = sns_valid_i && taking && (pix_idx_q >= first_now)
		&& ({1'b0, pix_idx_q} < win_end);
	assign ptr_next = wr_ptr_q + CW'(in_win);
	assign line_done = line_end && taking;
	assign lines_reached = (line_cnt_q + LW'(1)) == lines_eff_q;
	// Room check for the next line guards the buffer against overflow
	assign no_room = ({1'b0, ptr_next} + (CW+1)'(app_q.pixel_count)) > DEPTH_C;
	assign frame_close = (line_done && (lines_reached || no_room || halting))
		|| (halting && !mid_line && !line_done && line_cnt_q != '0);
	assign stop_now = (halting && (line_end || !mid_line))
		|| (frame_close && single_frame_i);
	assign apply = pend_q && !acq_q;

	// Write clamps: count at least one, lines within the absolute limit
	logic [PW-1:0] wr_count;
	logic [LW-1:0] wr_lines;
	assign wr_count = (geom_i.pixel_count == '0) ? PW'(1) :
		(geom_i.pixel_count > PW'(SENSOR_PIX)) ? PW'(SENSOR_PIX) : geom_i.pixel_count;
	assign wr_lines = (geom_i.lines == '0) ? LW'(1) :
		(geom_i.lines > LW'(`LFA_LINES_ABS_MAX)) ? LW'(`LFA_LINES_ABS_MAX) : geom_i.lines;

	// Transmit side
	logic tx_load, rd_last;
	logic [`LFA_DATA_W-1:0] rd_data;
	assign tx_load = full_q[rd_buf_q] && (!tx_valid_q || tx_ready_i);
	assign rd_last = (rd_cnt_q == words_q[rd_buf_q] - CW'(1));

	lfa_frame_buf #(
		.DATA_W(`LFA_DATA_W),
		.ADDR_W(BW + CW)
	) u_buf (
		.core_clk_i(core_clk_i),
		.wr_en_i(in_win),
		.wr_addr_i({wr_buf_q, wr_ptr_q}),
		.wr_data_i(sns_data_i),
		.rd_addr_i({rd_buf_q, rd_cnt_q}),
		.rd_data_o(rd_data)
	);

	// Per-buffer full flags; a close in the same cycle as a drain wins
	genvar gi;
	generate
		for (gi = 0; gi < NBUF; gi++) begin : g_full
			logic set_b, clr_b;
			assign set_b = frame_close && (wr_buf_q == BW'(gi));
			assign clr_b = tx_load && rd_last && (rd_buf_q == BW'(gi));
			always_ff @(posedge core_clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					full_q[gi] <= 1'b0;
				end else begin
					full_q[gi] <= set_b || (full_q[gi] && !clr_b);
				end
			end
		end
	endgenerate

	// Acquisition state and halt handling
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acq_q <= 1'b0;
			halt_pend_q <= 1'b0;
		end else if (stop_now) begin
			acq_q <= 1'b0;
			halt_pend_q <= 1'b0;
		end else if (halting) begin
			halt_pend_q <= 1'b1;
		end else if (acq_begin_command_i) begin
			acq_q <= 1'b1;
		end
	end

	// Pixel index within the sensor line
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pix_idx_q <= '0;
			take_q <= 1'b0;
			cur_first_q <= '0;
			cur_count_q <= '0;
		end else if (sns_valid_i) begin
			pix_idx_q <= sns_last_i ? '0 : pix_idx_q + PW'(1);
			take_q <= taking && !sns_last_i;
			cur_first_q <= first_now;
			cur_count_q <= count_now;
		end
	end

	// Line accumulation into the current write buffer
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_buf_q <= '0;
			wr_ptr_q <= '0;
			line_cnt_q <= '0;
		end else if (frame_close) begin
			wr_buf_q <= (wr_buf_q == BW'(NBUF-1)) ? '0 : wr_buf_q + BW'(1);
			wr_ptr_q <= '0;
			line_cnt_q <= '0;
		end else if (stop_now) begin
			wr_ptr_q <= '0;
			line_cnt_q <= '0;
		end else begin
			wr_ptr_q <= ptr_next;
			if (line_done) begin
				line_cnt_q <= line_cnt_q + LW'(1);
			end
		end
	end

	// Frame size record, captured as the frame closes
	always_ff @(posedge core_clk_i) begin
		if (frame_close) begin
			words_q[wr_buf_q] <= ptr_next;
			width_q[wr_buf_q] <= cur_count_q;
		end
	end

	// Geometry: first pixel applies at once, the rest waits while acquiring
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			app_q <= '{PW'(`LFA_RST_FIRST), PW'(`LFA_RST_COUNT), LW'(`LFA_RST_LINES)};
			pend_geom_q <= '{PW'(`LFA_RST_FIRST), PW'(`LFA_RST_COUNT), LW'(`LFA_RST_LINES)};
			lines_eff_q <= LW'(`LFA_RST_LINES);
			pend_q <= 1'b0;
		end else begin
			if (geom_wr_i) begin
				app_q.aoi_first_pixel <= (geom_i.aoi_first_pixel >= PW'(SENSOR_PIX)) ?
					PW'(SENSOR_PIX - 1) : geom_i.aoi_first_pixel;
				pend_geom_q.pixel_count <= wr_count;
				pend_geom_q.lines <= wr_lines;
				pend_q <= 1'b1;
			end else if (apply) begin
				pend_q <= 1'b0;
			end
			if (apply) begin
				app_q.pixel_count <= pend_geom_q.pixel_count;
				app_q.lines <= pend_geom_q.lines;
				lines_eff_q <= pend_geom_q.lines;
			end else if (line_done && no_room && !lines_reached && !halting) begin
				lines_eff_q <= line_cnt_q + LW'(1);
			end
		end
	end

	// Sticky overrun; a new drop beats a clear in the same cycle
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			overrun_q <= 1'b0;
		end else begin
			overrun_q <= start_drop || (overrun_q && !overrun_clr_i);
		end
	end

	// Reported limits; host keeps first plus count within the line
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			max_q <= '0;
		end else begin
			max_q.aoi_first_pixel <= PW'(SENSOR_PIX) - app_q.pixel_count;
			max_q.pixel_count <= PW'(SENSOR_PIX) - app_q.aoi_first_pixel;
			max_q.lines <= LW'(`LFA_LINES_ABS_MAX);
		end
	end

	// Frame readout; output words are registered for a clean handshake
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_q <= '0;
			tx_valid_q <= 1'b0;
			rd_buf_q <= '0;
			rd_cnt_q <= '0;
			col_q <= '0;
		end else if (tx_load) begin
			tx_q.data <= rd_data;
			tx_q.sof <= (rd_cnt_q == '0);
			tx_q.eol <= (col_q == width_q[rd_buf_q] - PW'(1));
			tx_q.eof <= rd_last;
			tx_valid_q <= 1'b1;
			col_q <= (col_q == width_q[rd_buf_q] - PW'(1)) ? '0 : col_q + PW'(1);
			rd_cnt_q <= rd_last ? '0 : rd_cnt_q + CW'(1);
			if (rd_last) begin
				rd_buf_q <= (rd_buf_q == BW'(NBUF-1)) ? '0 : rd_buf_q + BW'(1);
			end
		end else if (tx_ready_i) begin
			tx_valid_q <= 1'b0;
		end
	end

	// Output drive, all from flip-flops
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			geom_o <= '0;
			geom_pend_o <= 1'b0;
			geom_inc_o <= '0;
		end else begin
			geom_o <= '{app_q.aoi_first_pixel, app_q.pixel_count, lines_eff_q};
			geom_pend_o <= pend_q;
			geom_inc_o <= '{PW'(`LFA_INC_FIRST), PW'(`LFA_INC_COUNT), LW'(`LFA_INC_LINES)};
		end
	end

	assign geom_max_o = max_q;
	assign acquiring_o = acq_q;
	assign overrun_o = overrun_q;
	assign tx_o = tx_q;
	assign tx_valid_o = tx_valid_q;
endmodule : lfa_top

// ### lfa_defines.svh
`ifndef LFA_DEFINES_SVH
`define LFA_DEFINES_SVH
`define LFA_SENSOR_PIX 2048
`define LFA_LINES_ABS_MAX 12288
`define LFA_LINES_FLOOR 512
`define LFA_BUF_DEPTH 16384
`define LFA_NBUF 2
`define LFA_PIX_W 12
`define LFA_LINE_W 14
`define LFA_CNT_W 15
`define LFA_DATA_W 8
`define LFA_INC_FIRST 1
`define LFA_INC_COUNT 1
`define LFA_INC_LINES 1
`define LFA_RST_FIRST 0
`define LFA_RST_COUNT 2048
`define LFA_RST_LINES 512
`endif

// ### lfa_pkg.sv
`include "lfa_defines.svh"
package lfa_pkg;
	// Area of interest and frame height, as written or as applied
	typedef struct packed {
		logic [`LFA_PIX_W-1:0] aoi_first_pixel;
		logic [`LFA_PIX_W-1:0] pixel_count;
		logic [`LFA_LINE_W-1:0] lines;
	} lfa_geom_t;
	// One word toward the network transmit path
	typedef struct packed {
		logic [`LFA_DATA_W-1:0] data;
		logic sof;
		logic eol;
		logic eof;
	} lfa_tx_t;
endpackage : lfa_pkg

// ### lfa_frame_buf.sv
`timescale 1ns/100ps
module lfa_frame_buf #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 15
) (
	// Clock
	input wire logic core_clk_i,
	// Write port
	input wire logic wr_en_i,
	input wire logic [ADDR_W-1:0] wr_addr_i,
	input wire logic [DATA_W-1:0] wr_data_i,
	// Read port, combinational
	input wire logic [ADDR_W-1:0] rd_addr_i,
	output logic [DATA_W-1:0] rd_data_o
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// No reset on storage; contents are only read after being written
	always_ff @(posedge core_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	assign rd_data_o = mem[rd_addr_i];
endmodule : lfa_frame_buf

// ### lfa_top_monitor.sv
`timescale 1ns/100ps
module lfa_top_monitor import lfa_pkg::*; (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Inputs watched
	input wire logic acq_begin_command_i,
	input wire logic overrun_clr_i,
	input wire logic tx_ready_i,
	// Outputs watched
	input wire lfa_geom_t geom_o,
	input wire logic geom_pend_o,
	input wire lfa_geom_t geom_max_o,
	input wire lfa_geom_t geom_inc_o,
	input wire logic acquiring_o,
	input wire logic overrun_o,
	input wire lfa_tx_t tx_o,
	input wire logic tx_valid_o
);
	// One domain, so one clocking and one disable serve every property
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	// Limits lag the applied values, so give them two edges after release
	lines_cap_a: assert property (geom_o.lines <= 14'h3000)
		else $error("lines above absolute cap");
	max_floor_a: assert property ($past(rstn_i, 2) |-> geom_max_o.lines >= 14'h0200)
		else $error("reported lines maximum below floor");
	inc_one_a: assert property ($past(rstn_i, 2) |-> geom_inc_o == {12'h001, 12'h001, 14'h0001})
		else $error("increments not one");
	pend_hold_a: assert property (geom_pend_o && acquiring_o |=> $stable(geom_o.pixel_count))
		else $error("pixel count changed while pending");
	pend_apply_a: assert property (geom_pend_o && !acquiring_o |-> ##[1:2] !geom_pend_o)
		else $error("pending change not applied when idle");
	begin_need_a: assert property ($rose(acquiring_o) |-> $past(acq_begin_command_i))
		else $error("acquisition rose without begin");
	tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_o))
		else $error("transmit word dropped before taken");
	ovr_sticky_a: assert property (overrun_o && !overrun_clr_i |=> overrun_o)
		else $error("overrun flag lost without clear");
	// Main scenarios
	cover property ($fell(acquiring_o));
	cover property ($rose(overrun_o));
	cover property (tx_valid_o && tx_ready_i && tx_o.eof);
endmodule : lfa_top_monitor
bind lfa_top lfa_top_monitor lfa_top_monitor_i (.core_clk_i, .rstn_i, .acq_begin_command_i,
	.overrun_clr_i, .tx_ready_i, .geom_o, .geom_pend_o, .geom_max_o, .geom_inc_o,
	.acquiring_o, .overrun_o, .tx_o, .tx_valid_o);

// ### lfa_tx_sink.sv
`timescale 1ns/100ps
module lfa_tx_sink import lfa_pkg::*; (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Stall request from the bench
	input wire logic stall_i,
	// Transmit stream
	input wire lfa_tx_t tx_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	// Last frame seen, and a running count of frame ends
	output logic [15:0] words_o,
	output logic [15:0] first_o,
	output logic [15:0] last_o,
	output logic [15:0] eofs_o,
	output logic [15:0] eols_o
);
	logic slow_q;
	// Half-rate acceptance keeps the design holding words between takes
	assign tx_ready_o = slow_q && !stall_i;
	// Word count restarts on each start of frame
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			slow_q <= 1'b0;
			words_o <= 16'h0000;
			first_o <= 16'h0000;
			last_o <= 16'h0000;
			eofs_o <= 16'h0000;
			eols_o <= 16'h0000;
		end else begin
			slow_q <= !slow_q;
			if (tx_valid_i && tx_ready_o) begin
				words_o <= tx_i.sof ? 16'h0001 : words_o + 16'h0001;
				if (tx_i.sof) first_o <= 16'(tx_i.data);
				last_o <= 16'(tx_i.data);
				eofs_o <= eofs_o + 16'(tx_i.eof);
				// Line ends of the current frame only
				eols_o <= tx_i.sof ? 16'(tx_i.eol) : eols_o + 16'(tx_i.eol);
			end
		end
	end
endmodule : lfa_tx_sink

// ### lfa_tb_top.sv
`timescale 1ns/100ps
module tb_top import lfa_pkg::*;;
	localparam int SP = 64;
	logic core_clk_i = 0, rstn_i = 0, sns_valid_i = 0, sns_last_i = 0, stall = 0;
	logic acq_begin_command_i = 0, acq_halt_command_i = 0, single_frame_i = 0;
	logic geom_wr_i = 0, overrun_clr_i = 0, tx_ready_i, tx_valid_o;
	logic geom_pend_o, acquiring_o, overrun_o;
	logic [7:0] sns_data_i = 8'h00;
	logic [15:0] words, first, last, eofs, eols;
	lfa_geom_t geom_i = '0, geom_o, geom_max_o, geom_inc_o;
	lfa_tx_t tx_o;
	int errors = 0, comparisons = 0, e = 0;
	// Rows: first, count, lines, then expected words, first data, last data
	int rows [3][6] = '{'{0, 8, 4, 32, 0, 7}, '{5, 16, 2, 32, 5, 20}, '{63, 1, 3, 3, 63, 63}};
	// Clock
	always #20 core_clk_i = !core_clk_i;
	// Small buffers make the depth limit reachable in a short run
	lfa_top #(.SENSOR_PIX(SP), .DEPTH(64), .NBUF(2)) lfa_top_i (.core_clk_i, .rstn_i,
		.sns_valid_i, .sns_data_i, .sns_last_i, .acq_begin_command_i, .acq_halt_command_i,
		.single_frame_i, .geom_wr_i, .geom_i, .overrun_clr_i, .geom_o, .geom_pend_o,
		.geom_max_o, .geom_inc_o, .acquiring_o, .overrun_o, .tx_o, .tx_valid_o, .tx_ready_i);
	lfa_tx_sink lfa_tx_sink_i (.core_clk_i, .rstn_i, .stall_i(stall), .tx_i(tx_o),
		.tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .words_o(words), .first_o(first),
		.last_o(last), .eofs_o(eofs), .eols_o(eols));
	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] s);
		comparisons++;
		if (s !== x) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	// Pixel data is its own index; halt pulses at pixel h, -1 for none
	task automatic line(input int h);
		for (int i = 0; i < SP; i++) begin
			@(posedge core_clk_i);
			sns_valid_i <= 1'b1;
			sns_data_i <= 8'(i);
			sns_last_i <= (i == SP - 1);
			acq_halt_command_i <= (i == h);
		end
		@(posedge core_clk_i);
		sns_valid_i <= 1'b0;
		sns_last_i <= 1'b0;
		acq_halt_command_i <= 1'b0;
	endtask : line
	task automatic setg(input int f, input int c, input int l, input logic sf);
		@(posedge core_clk_i);
		geom_i <= '{12'(f), 12'(c), 14'(l)};
		geom_wr_i <= 1'b1;
		single_frame_i <= sf;
		@(posedge core_clk_i);
		geom_wr_i <= 1'b0;
	endtask : setg
	// Begin when b is set, halt otherwise
	task automatic cmd(input logic b);
		@(posedge core_clk_i);
		acq_begin_command_i <= b;
		acq_halt_command_i <= !b;
		@(posedge core_clk_i);
		acq_begin_command_i <= 1'b0;
		acq_halt_command_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
	endtask : cmd
	task automatic wait_eof();
		for (int k = 0; k < 3000 && eofs !== 16'(e); k++) @(posedge core_clk_i);
		@(negedge core_clk_i);
		// A wait that runs out shows here as a missing frame
		chk("eofs", 16'(e), eofs);
	endtask : wait_eof
	task automatic stop_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	// Watchdog well past the expected run length
	initial begin
		#2000000;
		errors++;
		stop_test();
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(negedge core_clk_i);
		chk("acquiring", 0, acquiring_o);
		chk("tx_valid", 0, tx_valid_o);
		chk("lines_max", 12288, geom_max_o.lines);
		chk("inc_first", 1, geom_inc_o.aoi_first_pixel);
		chk("inc_lines", 1, geom_inc_o.lines);
		$display("reset test done");
		// Host keeps first pixel plus count within the line in every row
		foreach (rows[i]) begin
			setg(rows[i][0], rows[i][1], rows[i][2], 1'b1);
			cmd(1'b1);
			repeat (rows[i][2]) line(-1);
			e++;
			wait_eof();
			chk("words", 16'(rows[i][3]), words);
			chk("first", 16'(rows[i][4]), first);
			chk("last", 16'(rows[i][5]), last);
			chk("eols", 16'(rows[i][2]), eols);
			chk("acquiring", 0, acquiring_o);
			$display("row %0d test done", i);
		end
		// Limits follow the last row: first pixel 63, one pixel wide
		chk("max_first", 16'(SP - 1), geom_max_o.aoi_first_pixel);
		chk("max_count", 1, geom_max_o.pixel_count);
		chk("inc_count", 1, geom_inc_o.pixel_count);
		// Continuous mode holds a count change until halt
		setg(0, 8, 2, 1'b0);
		cmd(1'b1);
		repeat (2) line(-1);
		setg(0, 4, 2, 1'b0);
		// Pending flag is registered once more before it reaches the port
		repeat (2) @(negedge core_clk_i);
		chk("pending", 1, geom_pend_o);
		repeat (2) line(-1);
		e += 2;
		wait_eof();
		chk("words", 16, words);
		cmd(1'b0);
		@(negedge core_clk_i);
		chk("pending", 0, geom_pend_o);
		chk("count", 4, geom_o.pixel_count);
		$display("pending test done");
		// Halt in mid-line sends a partial frame, then refuses lines
		setg(0, 8, 4, 1'b1);
		cmd(1'b1);
		line(-1);
		line(20);
		e++;
		wait_eof();
		chk("words", 16, words);
		chk("acquiring", 0, acquiring_o);
		line(-1);
		repeat (200) @(posedge core_clk_i);
		chk("eofs", 16'(e), eofs);
		cmd(1'b1);
		repeat (4) line(-1);
		e++;
		wait_eof();
		chk("words", 32, words);
		$display("halt test done");
		// Stalled sink: two buffers fill, the next line is dropped
		setg(0, 8, 4, 1'b0);
		stall <= 1'b1;
		cmd(1'b1);
		repeat (8) line(-1);
		@(negedge core_clk_i);
		chk("overrun", 0, overrun_o);
		line(-1);
		@(negedge core_clk_i);
		chk("overrun", 1, overrun_o);
		cmd(1'b0);
		stall <= 1'b0;
		e += 2;
		wait_eof();
		chk("eofs", 16'(e), eofs);
		@(posedge core_clk_i);
		overrun_clr_i <= 1'b1;
		@(posedge core_clk_i);
		overrun_clr_i <= 1'b0;
		@(negedge core_clk_i);
		chk("overrun", 0, overrun_o);
		$display("overrun test done");
		// Frame taller than the buffer holds is cut to what fits
		setg(0, 8, 20, 1'b1);
		cmd(1'b1);
		repeat (8) line(-1);
		e++;
		wait_eof();
		chk("words", 64, words);
		// A 64 word buffer holds eight lines of eight pixels
		chk("lines", 8, 16'(geom_o.lines));
		$display("lowering test done");
		stop_test();
	end
endmodule : tb_top
